// file: hw/rmsp_top.sv
// module: reset pin sequencing, strap latching and pin state control
//
// Overview of operation
// - in reset: address hi-z, chip selects high while the three-state pin is low
// - mode latched only when reset releases
// - capture debug, memory, mode, port configuration
// - clock mode latched when reset asserts
// - decode single, 16-bit or 8-bit expanded
// - bus fault low ignores width bit
// - address 18..3 ports in single-chip, else bus
// - data ports G/H per mode, bus otherwise
// - low address disabled only in single-chip
// - high address functions fixed at release
// - data strap high selects default option
// - first bus cycle ten cycles after release
// - three-state pin floats chip selects during reset
// - other module gpio pins hi-z in reset
// - reset pin driven low 512 cycles first
`timescale 1ns/1ns
module rmsp_top (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic [15:0] data_strap_i,
	input  wire logic        bus_fault_strap_i,
	input  wire logic        breakpoint_debug_pin_i,
	input  wire logic        clock_mode_strap_i,
	input  wire logic        fast_reference_strap_i,
	input  wire logic        three_state_control_pin_i,
	output logic             reset_pin_low_o,
	output logic             ebi_release_o,
	output logic             bus_start_o,
	output logic             addr_ctl_hiz_o,
	output logic             gpio_hiz_o,
	output logic             cs_drive_high_o,
	output logic             cs_hiz_o,
	output logic [1:0]       mode_o,
	output logic             debug_enable_o,
	output logic [3:0]       mem_enable_o,
	output logic [10:0]      port_cfg_o,
	output logic             clk_mode_o,
	output logic             fast_ref_o,
	output logic [4:0]       hi_addr_cs_o,
	output logic             addr_bus_en_o,
	output logic             port_g_en_o,
	output logic             port_h_en_o,
	output logic             low_address_disable_bit_o
);
	rmsp_strap_if         sb ();
	rmsp_pkg::rmsp_state_t r_reg;
	rmsp_pkg::rmsp_state_t r_next;

	logic [15:0] dat;
	logic        fault;
	logic        three_state_control_pin;

	////////////////////////////////////////////////////////////////////////
	// every pin is asynchronous to mclk_i, so all but rst_i pass the synchroniser
	rmsp_strap_sync u_sync (
		.mclk_i (mclk_i),
		.pins_i ({three_state_control_pin_i, fast_reference_strap_i,
		          clock_mode_strap_i, breakpoint_debug_pin_i,
		          bus_fault_strap_i, data_strap_i}),
		.sb     (sb.src)
	);

	assign dat   = sb.straps[rmsp_pkg::SB_DATA_LO +: 16];
	assign fault = sb.straps[rmsp_pkg::SB_BUS_FAULT];
	assign three_state_control_pin   = sb.straps[rmsp_pkg::SB_TSC];

	////////////////////////////////////////////////////////////////////////
	// mode decode; width bit is only looked at with bus fault high
	function automatic rmsp_pkg::rmsp_mode_t decode_mode(
		input logic bf,
		input logic wb
	);
		rmsp_pkg::rmsp_mode_t m;
		if (!bf) begin
			m = rmsp_pkg::MODE_SINGLE;
		end else if (!wb) begin
			m = rmsp_pkg::MODE_EXP16;
		end else begin
			m = rmsp_pkg::MODE_EXP8;
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// sequencer and latches
	always_comb begin
		r_next           = r_reg;
		r_next.bus_start = 1'b0;
		r_next.rst_d     = rst_i;
		if (rst_i) begin
			// held reset request: pin low, counter parked
			r_next.st  = rmsp_pkg::SEQ_REQ;
			r_next.cnt = '0;
			if (!r_reg.rst_d) begin
				r_next.clkm = sb.straps[rmsp_pkg::SB_CLK_MODE];
				r_next.fref = sb.straps[rmsp_pkg::SB_FAST_REF];
			end
		end else begin
			case (r_reg.st)
				rmsp_pkg::SEQ_REQ: begin
					r_next.st  = rmsp_pkg::SEQ_HOLD;
					r_next.cnt = '0;
				end
				rmsp_pkg::SEQ_HOLD: begin
					if (r_reg.cnt == rmsp_pkg::HOLD_CYC - 10'h001) begin
						// release: the only place the data, bus fault and debug straps are sampled
						r_next.st    = rmsp_pkg::SEQ_SETTLE;
						r_next.cnt   = '0;
						r_next.mode  = decode_mode(fault,
						               dat[rmsp_pkg::DB_WIDTH_SEL]);
						r_next.dbg   = sb.straps[rmsp_pkg::SB_BREAKPOINT_DEBUG_PIN];
						r_next.mem   = dat[rmsp_pkg::DB_MEM_LO +: 4];
						r_next.pcfg  = {dat[11:2], dat[0]};
						// high address pin i is a select while d7..d(3+i)
						// are all high; single-chip keeps them non-address
						for (int i = 0; i < 5; i++) begin
							// bits below 3+i are forced high so they drop out;
							// a plain shift would pull zeros into the and
							r_next.hi_cs[i] = (&(dat[7:3] |
							                  ((5'h01 << i) - 5'h01))) |
							                  !fault;
						end
					end else begin
						r_next.cnt = r_reg.cnt + 10'h001;
					end
				end
				rmsp_pkg::SEQ_SETTLE: begin
					if (r_reg.cnt == rmsp_pkg::BUS_DLY_CYC - 10'h001) begin
						r_next.st        = rmsp_pkg::SEQ_RUN;
						r_next.bus_start = 1'b1;
					end else begin
						r_next.cnt = r_reg.cnt + 10'h001;
					end
				end
				default: begin
					// latched fields simply hold until the next reset
					r_next.st = rmsp_pkg::SEQ_RUN;
				end
			endcase
		end
		// pin states follow the sequencer state being entered
		r_next.pin_low  = (r_next.st == rmsp_pkg::SEQ_REQ) ||
		                  (r_next.st == rmsp_pkg::SEQ_HOLD);
		r_next.addr_hiz = r_next.pin_low;
		r_next.gpio_hiz = r_next.pin_low;
		r_next.cs_hiz   = r_next.pin_low && three_state_control_pin;
		r_next.cs_high  = r_next.pin_low && !three_state_control_pin;
		r_next.ebi_rel  = (r_next.st == rmsp_pkg::SEQ_RUN);
		// port availability from the latched mode
		r_next.addr_bus = (r_next.mode != rmsp_pkg::MODE_SINGLE);
		r_next.port_g   = (r_next.mode == rmsp_pkg::MODE_SINGLE);
		r_next.port_h   = (r_next.mode != rmsp_pkg::MODE_EXP16);
		r_next.abd      = (r_next.mode == rmsp_pkg::MODE_SINGLE);
	end

	// no reset term here, rst_i acts only through r_next; clock mode is caught above
	always_ff @(posedge mclk_i) begin
		r_reg <= r_next;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from the state register
	assign reset_pin_low_o           = r_reg.pin_low;
	assign ebi_release_o             = r_reg.ebi_rel;
	assign bus_start_o               = r_reg.bus_start;
	assign addr_ctl_hiz_o            = r_reg.addr_hiz;
	assign gpio_hiz_o                = r_reg.gpio_hiz;
	assign cs_drive_high_o           = r_reg.cs_high;
	assign cs_hiz_o                  = r_reg.cs_hiz;
	assign mode_o                    = r_reg.mode;
	assign debug_enable_o            = r_reg.dbg;
	assign mem_enable_o              = r_reg.mem;
	assign port_cfg_o                = r_reg.pcfg;
	assign clk_mode_o                = r_reg.clkm;
	assign fast_ref_o                = r_reg.fref;
	assign hi_addr_cs_o              = r_reg.hi_cs;
	assign addr_bus_en_o             = r_reg.addr_bus;
	assign port_g_en_o               = r_reg.port_g;
	assign port_h_en_o               = r_reg.port_h;
	assign low_address_disable_bit_o = r_reg.abd;

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	a_release_after_hold: assert property (
		$fell(reset_pin_low_o) |-> $past(r_reg.cnt) == 10'h1FF)
		else $error("reset pin released before full hold time");

	a_mode_only_release: assert property (
		$changed(mode_o) && !$past(rst_i) |->
		$past(r_reg.st) == rmsp_pkg::SEQ_HOLD)
		else $error("mode changed outside reset release");

	a_mode_decode_ok: assert property (
		$fell(reset_pin_low_o) |->
		mode_o == (!$past(fault) ? 2'h0 :
		           ($past(dat[1]) ? 2'h2 : 2'h1)))
		else $error("mode decode mismatch");

	a_mem_cfg_capture: assert property (
		$fell(reset_pin_low_o) |-> mem_enable_o == $past(dat[15:12])
		&& port_cfg_o == {$past(dat[11:2]), $past(dat[0])})
		else $error("configuration not captured at release");

	a_first_bus_ten: assert property (
		$fell(reset_pin_low_o) |-> !bus_start_o ##10 bus_start_o)
		else $error("first bus cycle not ten cycles after release");

	a_pins_hiz_reset: assert property (
		reset_pin_low_o |-> addr_ctl_hiz_o && gpio_hiz_o && !ebi_release_o)
		else $error("pins not floated during reset");

	a_tsc_floats_cs: assert property (
		reset_pin_low_o && $past(three_state_control_pin) |-> cs_hiz_o && !cs_drive_high_o)
		else $error("three-state input did not float chip selects");

	a_cfg_held_run: assert property (
		ebi_release_o && $past(ebi_release_o) |->
		$stable(mode_o) && $stable(port_cfg_o) && $stable(hi_addr_cs_o))
		else $error("latched configuration changed while running");

	a_single_ports: assert property (
		mode_o == 2'h0 && ebi_release_o |->
		!addr_bus_en_o && port_g_en_o && port_h_en_o &&
		low_address_disable_bit_o)
		else $error("single-chip port map wrong");

	a_clk_mode_latch: assert property (
		@(posedge mclk_i) disable iff (1'b0)
		!rst_i ##1 rst_i |=>
		clk_mode_o == $past(sb.straps[rmsp_pkg::SB_CLK_MODE]) &&
		fast_ref_o == $past(sb.straps[rmsp_pkg::SB_FAST_REF]))
		else $error("clock mode not latched at reset assertion");

	c_single_run: cover property (ebi_release_o && mode_o == 2'h0);
	c_exp16_run:  cover property (ebi_release_o && mode_o == 2'h1);
	c_exp8_run:   cover property (ebi_release_o && mode_o == 2'h2);
	c_tsc_reset:  cover property (cs_hiz_o);
endmodule

// file: hw/rmsp_pkg.sv
// package: constants and types for the reset mode strap sequencer
package rmsp_pkg;

	////////////////////////////////////////////////////////////////////////
	// strap vector layout, as sampled from the pins
	localparam int unsigned STRAP_W      = 21;
	localparam int unsigned SB_DATA_LO   = 0;  // data lines 15..0
	localparam int unsigned SB_BUS_FAULT = 16;
	localparam int unsigned SB_BREAKPOINT_DEBUG_PIN      = 17;
	localparam int unsigned SB_CLK_MODE  = 18;
	localparam int unsigned SB_FAST_REF  = 19;
	localparam int unsigned SB_TSC       = 20;

	// data bus strap field positions
	localparam int unsigned DB_WIDTH_SEL = 1;  // width_select_strap_bit
	localparam int unsigned DB_MEM_LO    = 12; // memory enables 15..12
	localparam int unsigned DB_CS_LO     = 3;  // high address selects 7..3

	////////////////////////////////////////////////////////////////////////
	// timing counts, in system clock cycles
	localparam int unsigned CNT_W = 10;
	localparam logic [9:0] HOLD_CYC   = 10'h200; // reset pin low time
	localparam logic [9:0] BUS_DLY_CYC = 10'h00A; // release to first bus cycle

	////////////////////////////////////////////////////////////////////////
	// reset values of the latched configuration; not loaded anywhere, reset leaves the fields held
	localparam logic [3:0]  MEM_RST   = 4'h0;
	localparam logic [10:0] PCFG_RST  = 11'h7FF;
	localparam logic [4:0]  HI_CS_RST = 5'h1F;

	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_EXP16,
		MODE_EXP8
	} rmsp_mode_t;

	typedef enum logic [1:0] {
		SEQ_RUN,
		SEQ_REQ,
		SEQ_HOLD,
		SEQ_SETTLE
	} rmsp_seq_t;

	typedef struct packed {
		rmsp_seq_t          st;
		logic [CNT_W-1:0]   cnt;
		logic               rst_d;
		rmsp_mode_t         mode;
		logic               dbg;
		logic [3:0]         mem;
		logic [10:0]        pcfg;
		logic               clkm;
		logic               fref;
		logic [4:0]         hi_cs;
		logic               pin_low;
		logic               bus_start;
		logic               ebi_rel;
		logic               addr_hiz;
		logic               gpio_hiz;
		logic               cs_high;
		logic               cs_hiz;
		logic               addr_bus;
		logic               port_g;
		logic               port_h;
		logic               abd;
	} rmsp_state_t;

	typedef struct packed {
		logic [STRAP_W-1:0] meta;
		logic [STRAP_W-1:0] sync;
	} rmsp_sync_t;

endpackage

// file: hw/rmsp_strap_if.sv
// interface: synchronised strap levels between the sampler and sequencer
`timescale 1ns/1ns
interface rmsp_strap_if;
	logic [rmsp_pkg::STRAP_W-1:0] straps;

	modport src (output straps);
	modport dst (input  straps);
endinterface

// file: hw/rmsp_strap_sync.sv
// module: two flip-flop synchroniser for all strap and control pins
`timescale 1ns/1ns
module rmsp_strap_sync (
	input  wire logic                         mclk_i,
	input  wire logic [rmsp_pkg::STRAP_W-1:0] pins_i,
	rmsp_strap_if.src                         sb
);
	rmsp_pkg::rmsp_sync_t r_reg;
	rmsp_pkg::rmsp_sync_t r_next;

	////////////////////////////////////////////////////////////////////////
	// first stage feeds only the second stage, never any logic
	always_comb begin
		r_next.meta = pins_i;
		r_next.sync = r_reg.meta;
	end

	always_ff @(posedge mclk_i) begin
		r_reg <= r_next;
	end

	assign sb.straps = r_reg.sync;
endmodule

// file: sim/rmsp_strap_board.sv
// board side: strap drivers; data, bus fault and debug ones act only around reset
`timescale 1ns/1ns
module rmsp_strap_board (
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	input  wire logic        reset_pin_low_i,
	input  wire logic [15:0] cfg_data_i,
	input  wire logic        cfg_bus_fault_i,
	input  wire logic        cfg_breakpoint_debug_pin_i,
	input  wire logic        cfg_clk_mode_i,
	input  wire logic        cfg_fast_ref_i,
	output logic      [15:0] data_strap_o,
	output logic             bus_fault_strap_o,
	output logic             breakpoint_debug_pin_o,
	output logic             clock_mode_strap_o,
	output logic             fast_reference_strap_o
);
	logic drive_reg = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// drivers follow the reset pin so they are off before any bus cycle;
	// no bus cycle runs while they drive, so strobe and direction gating
	// reduce to this enable in the model
	always_ff @(posedge mclk_i) begin
		drive_reg <= rst_i | reset_pin_low_i;
	end

	// released data lines float up on their pull-ups
	assign data_strap_o = drive_reg ? cfg_data_i : 16'hFFFF;
	// no pull-up on bus fault: once released it reads the other level
	assign bus_fault_strap_o = drive_reg ? cfg_bus_fault_i
	                                     : ~cfg_bus_fault_i;
	assign breakpoint_debug_pin_o = drive_reg ? cfg_breakpoint_debug_pin_i : ~cfg_breakpoint_debug_pin_i;
	// clock straps are tied on the board, always driven
	assign clock_mode_strap_o     = cfg_clk_mode_i;
	assign fast_reference_strap_o = cfg_fast_ref_i;
endmodule

// file: sim/rmsp_top_tb.sv
// testbench: reset sequencing, strap latching and pin states
`timescale 1ns/1ns
module rmsp_top_tb;
	typedef struct packed {
		logic        bf;
		logic [15:0] d;
		logic        bk;
		logic [1:0]  mode;
	} rmsp_row_t;

	logic        mclk_i = 1'b0;
	logic        rst_i  = 1'b1;
	logic        three_state_control_pin    = 1'b0;
	logic [15:0] c_d    = 16'hFFFF;
	logic        c_bf   = 1'b0;
	logic        c_bk   = 1'b0;
	logic        c_cm   = 1'b0;
	logic        c_fr   = 1'b0;
	logic [15:0] d_s;
	logic        bf_s, bk_s, cm_s, fr_s;
	logic        pin_low, external_bus_unit, bst, a_hiz, g_hiz, cs_hi, cs_z;
	logic [1:0]  mode;
	logic        dbg, clkm, fref, abus, pg, ph, abd;
	logic [3:0]  mem;
	logic [10:0] pcfg;
	logic [4:0]  hics;
	int          err_count = 0;
	int          checked   = 0;
	rmsp_row_t   rows[6] = '{'{1'b0, 16'hFFFF, 1'b1, 2'h0},
		'{1'b0, 16'h0000, 1'b0, 2'h0}, '{1'b1, 16'h0000, 1'b1, 2'h1},
		'{1'b1, 16'hFFFD, 1'b0, 2'h1}, '{1'b1, 16'hA5E7, 1'b1, 2'h2},
		'{1'b1, 16'h5A73, 1'b0, 2'h2}};

	////////////////////////////////////////////////////////////////////////
	// 50 MHz system clock
	always #10 mclk_i = ~mclk_i;

	rmsp_strap_board board (.mclk_i(mclk_i), .rst_i(rst_i),
		.reset_pin_low_i(pin_low), .cfg_data_i(c_d), .cfg_bus_fault_i(c_bf),
		.cfg_breakpoint_debug_pin_i(c_bk), .cfg_clk_mode_i(c_cm), .cfg_fast_ref_i(c_fr),
		.data_strap_o(d_s), .bus_fault_strap_o(bf_s),
		.breakpoint_debug_pin_o(bk_s), .clock_mode_strap_o(cm_s),
		.fast_reference_strap_o(fr_s));

	rmsp_top DUT (.mclk_i(mclk_i), .rst_i(rst_i), .data_strap_i(d_s),
		.bus_fault_strap_i(bf_s), .breakpoint_debug_pin_i(bk_s),
		.clock_mode_strap_i(cm_s), .fast_reference_strap_i(fr_s),
		.three_state_control_pin_i(three_state_control_pin), .reset_pin_low_o(pin_low),
		.ebi_release_o(external_bus_unit), .bus_start_o(bst), .addr_ctl_hiz_o(a_hiz),
		.gpio_hiz_o(g_hiz), .cs_drive_high_o(cs_hi), .cs_hiz_o(cs_z),
		.mode_o(mode), .debug_enable_o(dbg), .mem_enable_o(mem),
		.port_cfg_o(pcfg), .clk_mode_o(clkm), .fast_ref_o(fref),
		.hi_addr_cs_o(hics), .addr_bus_en_o(abus), .port_g_en_o(pg),
		.port_h_en_o(ph), .low_address_disable_bit_o(abd));

	////////////////////////////////////////////////////////////////////////
	// drive and sample at one fixed offset after the rising edge
	task automatic tick();
		@(posedge mclk_i);
		#2;
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: value got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp);
		checked++;
		if (got != exp) begin
			err_count++;
			$display("Error %0t: cycles got %0d exp %0d", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (err_count == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// pin states expected while the reset pin is held low
	task automatic chk_in_reset();
		cmp_bit(pin_low, 1'b1);
		cmp_bit(a_hiz, 1'b1);
		cmp_bit(g_hiz, 1'b1);
		cmp_bit(cs_hi, ~three_state_control_pin);
		cmp_bit(cs_z, three_state_control_pin);
		cmp_bit(external_bus_unit, 1'b0);
		cmp_bit(bst, 1'b0);
	endtask

	// latched configuration worked out from the strap row
	task automatic chk_cfg(input rmsp_row_t r);
		logic [4:0] h;
		logic [4:0] m;
		logic       sc;
		sc = (r.mode == 2'h0);
		for (int i = 0; i < 5; i++) begin
			m = 5'h1F << i;
			h[i] = sc | (&(r.d[7:3] | ~m));
		end
		cmp_vec(16'(mode), 16'(r.mode));
		cmp_bit(dbg, r.bk);
		cmp_vec(16'(mem), 16'(r.d[15:12]));
		cmp_vec(16'(pcfg), 16'({r.d[11:2], r.d[0]}));
		cmp_vec(16'(hics), 16'(h));
		cmp_bit(abus, ~sc);
		cmp_bit(pg, sc);
		cmp_bit(ph, r.mode != 2'h1);
		cmp_bit(abd, sc);
	endtask

	// release reset, time the pin and the first bus cycle
	task automatic release_seq();
		int n;
		n = 0;
		rst_i = 1'b0;
		do begin
			tick();
			n++;
		end while (pin_low !== 1'b0 && n < 600);
		if (n >= 600) begin
			err_count++;
			tally_and_finish();
		end
		cmp_cnt(n, 513);
		cmp_bit(a_hiz, 1'b0);
		cmp_bit(g_hiz, 1'b0);
		cmp_bit(cs_z, 1'b0);
		n = 0;
		do begin
			tick();
			n++;
		end while (bst !== 1'b1 && n < 20);
		if (n >= 20) begin
			err_count++;
			tally_and_finish();
		end
		cmp_cnt(n, 10);
		cmp_bit(external_bus_unit, 1'b1);
		tick();
		cmp_bit(bst, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence: table rows, then an aborted hold
	initial begin
		repeat (6) tick();
		chk_in_reset();
		release_seq();
		for (int i = 0; i < 6; i++) begin
			c_cm = i[0];
			c_fr = i[1];
			c_bf = ~rows[i].bf;
			c_d  = ~rows[i].d;
			c_bk = ~rows[i].bk;
			repeat (3) tick();
			rst_i = 1'b1;
			three_state_control_pin = i[0];
			repeat (4) tick();
			chk_in_reset();
			c_cm = ~i[0];
			c_fr = ~i[1];
			c_bf = rows[i].bf;
			c_d  = rows[i].d;
			c_bk = rows[i].bk;
			repeat (3) tick();
			release_seq();
			chk_cfg(rows[i]);
			cmp_bit(clkm, i[0]);
			cmp_bit(fref, i[1]);
			cmp_bit(cs_hi, 1'b0);
			repeat (20) tick();
			chk_cfg(rows[i]);
		end
		three_state_control_pin = 1'b0;
		rst_i = 1'b1;
		repeat (4) tick();
		rst_i = 1'b0;
		repeat (200) tick();
		cmp_bit(pin_low, 1'b1);
		rst_i = 1'b1;
		repeat (4) tick();
		chk_in_reset();
		chk_cfg(rows[5]);
		c_bf = rows[0].bf;
		c_d  = rows[0].d;
		c_bk = rows[0].bk;
		release_seq();
		chk_cfg(rows[0]);
		tally_and_finish();
	end
endmodule
